// ===== design/asp_pkg.sv
// Constants, register map and types for the asynchronous serial port.
// Assumes a single clock domain and an AXI4-Lite master on the CPU side.
// Operation
// - Transmitter and receiver each buffer sixteen characters in a FIFO.
// - Transmitter and receiver have their own enable and interrupt controls.
// - Receiver checks break, parity, overrun and framing, each its own flag.
// - Bit period comes from a sixteen-bit software divisor.
// - A frame starts with one start bit, then 1 to 8 data bits.
// - Optional parity bit: even, odd or none.
// - Frame ends with one or two stop bits.
// - Idle-line and address-bit multiprocessor wake-up modes are supported.
// - Transmit-buffer-free and shifter-drained flags are separate.
// - Receiver gives char-available, line-break and summary error flags.
// - Interrupt enables are separate; break has no enable of its own.
// - Registers are eight bits in the low byte; upper bits read zero.
// - Hardware measures the incoming bit rate automatically.
// - Written characters move to the transmit shifter, sent bit by bit.
// - Received characters go to the data buffer and emulation buffer.
// - Each bit holds a constant level for one whole bit period.
package asp_pkg;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned SKID_DEPTH    = 2;
  localparam int unsigned IDLE_GAP_BITS = 11;
  localparam int unsigned IDLE_DET_BITS = 10;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FRAME   = 8'h04;
  localparam logic [7:0] OFF_BAUD_HI = 8'h08;
  localparam logic [7:0] OFF_BAUD_LO = 8'h0c;
  localparam logic [7:0] OFF_TXD     = 8'h10;
  localparam logic [7:0] OFF_RXD     = 8'h14;
  localparam logic [7:0] OFF_RXEMU   = 8'h18;
  localparam logic [7:0] OFF_STAT    = 8'h1c;
  localparam logic [7:0] OFF_TXLVL   = 8'h20;
  localparam logic [7:0] OFF_RXLVL   = 8'h24;

  // Control register bit positions.
  localparam int unsigned CB_TX_EN  = 0;
  localparam int unsigned CB_RX_EN  = 1;
  localparam int unsigned CB_TX_IE  = 2;
  localparam int unsigned CB_RX_IE  = 3;
  localparam int unsigned CB_ERR_IE = 4;
  localparam int unsigned CB_ABAUD  = 5;
  localparam int unsigned CB_SLEEP  = 6;
  localparam int unsigned CB_TXADDR = 7;

  // Error flag positions inside the four-bit error vector.
  localparam int unsigned EB_BRK = 0;
  localparam int unsigned EB_PAR = 1;
  localparam int unsigned EB_OVR = 2;
  localparam int unsigned EB_FRM = 3;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  FRAME_RST = 8'h07;
  localparam logic [15:0] BAUD_RST  = 16'h0040;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       idle_mode;
    logic       addr_mode;
    logic       two_stop;
    logic       par_odd;
    logic       par_en;
    logic [2:0] len_m1;
  } asp_cfg_t;

  typedef enum logic [6:0] {
    TX_IDLE  = 7'h01,
    TX_GAP   = 7'h02,
    TX_START = 7'h04,
    TX_DATA  = 7'h08,
    TX_ADDR  = 7'h10,
    TX_PAR   = 7'h20,
    TX_STOP  = 7'h40
  } asp_tx_st_t;

  typedef enum logic [6:0] {
    RX_IDLE  = 7'h01,
    RX_START = 7'h02,
    RX_DATA  = 7'h04,
    RX_ADDR  = 7'h08,
    RX_PAR   = 7'h10,
    RX_STOP  = 7'h20,
    RX_BAUD  = 7'h40
  } asp_rx_st_t;
endpackage

// ===== design/asp_uart.sv
// Asynchronous serial port with FIFOs and an AXI4-Lite register slave.
// Assumes serial_rx_pin is already synchronous to aclk.
`timescale 1ns/1ps

module asp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Fill side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // Drain side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      level
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D+1);
  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  wire [AW-1:0]  last = AW'(D - 1);

  assign in_ready  = (cnt_ff != CW'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign level     = cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= (wr_ff == last) ? '0 : wr_ff + 1'b1;
      if (pop) rd_ff <= (rd_ff == last) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end
endmodule

module asp_uart #(
  parameter int unsigned DEPTH = asp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  output logic             serial_tx_pin,
  input  wire logic        serial_rx_pin,
  // Interrupt requests
  output logic             tx_irq,
  output logic             rx_irq
);
  localparam int unsigned LW = $clog2(DEPTH+1);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= asp_pkg::OFF_RXLVL);
  endfunction

  // Register file and bus state.
  logic [7:0]  ctrl_ff, frame_ff;
  logic [15:0] baud_ff;
  logic [3:0]  err_ff;
  logic        aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0]  aw_addr_ff;
  logic [7:0]  w_data_ff;
  logic        w_lo_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [7:0]  rdata_ff;
  asp_pkg::asp_cfg_t cfg;
  assign cfg = asp_pkg::asp_cfg_t'(frame_ff);

  // Transmitter state.
  asp_pkg::asp_tx_st_t tx_st_ff;
  logic [15:0] tx_cnt_ff;
  logic [3:0]  tx_bit_ff;
  logic [7:0]  tx_shift_ff;
  logic        tx_par_ff, tx_addr_ff, tx_pin_ff;

  // Receiver state.
  asp_pkg::asp_rx_st_t rx_st_ff;
  logic [15:0] rx_cnt_ff;
  logic [16:0] ab_cnt_ff;
  logic [3:0]  rx_bit_ff, idle_bits_ff;
  logic [7:0]  rx_shift_ff;
  logic        rx_par_ff, rx_ones_ff, rx_addr_ff, rx_idle_addr_ff;
  logic        rx_prev_ff;

  // Bus decode.
  wire do_wr    = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire wr_lo    = do_wr & w_lo_ff;
  wire ar_hs    = s_axi_arvalid & ~rvalid_ff;
  wire wr_ctrl  = wr_lo & (aw_addr_ff == asp_pkg::OFF_CTRL);
  wire wr_frame = wr_lo & (aw_addr_ff == asp_pkg::OFF_FRAME);
  wire wr_bhi   = wr_lo & (aw_addr_ff == asp_pkg::OFF_BAUD_HI);
  wire wr_blo   = wr_lo & (aw_addr_ff == asp_pkg::OFF_BAUD_LO);
  wire wr_txd   = wr_lo & (aw_addr_ff == asp_pkg::OFF_TXD);
  wire wr_stat  = wr_lo & (aw_addr_ff == asp_pkg::OFF_STAT);
  wire rd_rxd   = ar_hs & (s_axi_araddr == asp_pkg::OFF_RXD);

  // FIFO connections.
  logic          txf_in_ready, txf_valid, txf_pop;
  logic [7:0]    txf_data;
  logic [LW-1:0] txf_level, rxf_level;
  logic          sk_in_ready, sk_valid, rxf_in_ready, rxf_valid;
  logic [7:0]    sk_data, rxf_data;
  logic          rx_push;
  logic [7:0]    rx_word;

  asp_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (wr_txd),
    .in_ready  (txf_in_ready),
    .in_data   (w_data_ff),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .out_data  (txf_data),
    .level     (txf_level)
  );

  // Two-entry stage absorbs a finished frame while the FIFO is stalled.
  asp_fifo #(.W(8), .D(asp_pkg::SKID_DEPTH)) u_rx_skid (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_push),
    .in_ready  (sk_in_ready),
    .in_data   (rx_word),
    .out_valid (sk_valid),
    .out_ready (rxf_in_ready),
    .out_data  (sk_data),
    .level     ()
  );

  asp_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (sk_valid),
    .in_ready  (rxf_in_ready),
    .in_data   (sk_data),
    .out_valid (rxf_valid),
    .out_ready (rd_rxd),
    .out_data  (rxf_data),
    .level     (rxf_level)
  );

  // Status flags.
  wire tx_free   = txf_in_ready;
  // Drained means the shifter holds nothing; queued characters do not count.
  wire tx_empty  = (tx_st_ff == asp_pkg::TX_IDLE);
  wire rx_error  = |err_ff;
  wire [7:0] stat = {err_ff[asp_pkg::EB_FRM], err_ff[asp_pkg::EB_OVR],
                     err_ff[asp_pkg::EB_PAR], rx_error,
                     err_ff[asp_pkg::EB_BRK], rxf_valid, tx_empty, tx_free};
  assign tx_irq = ctrl_ff[asp_pkg::CB_TX_IE] & tx_free;
  assign rx_irq = (ctrl_ff[asp_pkg::CB_RX_IE] & rxf_valid)
                | (ctrl_ff[asp_pkg::CB_ERR_IE] & rx_error);

  // Read mux; only the low byte carries data.
  wire [7:0] rd_mux =
      (s_axi_araddr == asp_pkg::OFF_CTRL)    ? ctrl_ff :
      (s_axi_araddr == asp_pkg::OFF_FRAME)   ? frame_ff :
      (s_axi_araddr == asp_pkg::OFF_BAUD_HI) ? baud_ff[15:8] :
      (s_axi_araddr == asp_pkg::OFF_BAUD_LO) ? baud_ff[7:0] :
      (s_axi_araddr == asp_pkg::OFF_RXD)     ? rxf_data :
      (s_axi_araddr == asp_pkg::OFF_RXEMU)   ? rxf_data :
      (s_axi_araddr == asp_pkg::OFF_STAT)    ? stat :
      (s_axi_araddr == asp_pkg::OFF_TXLVL)   ? 8'(txf_level) :
      (s_axi_araddr == asp_pkg::OFF_RXLVL)   ? 8'(rxf_level) : 8'h00;

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = {24'h000000, rdata_ff};
  assign serial_tx_pin = tx_pin_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 8'h00;
      w_lo_ff    <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= asp_pkg::RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= asp_pkg::RESP_OKAY;
      rdata_ff   <= 8'h00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_lo_ff   <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (!is_mapped(aw_addr_ff) ||
                       (aw_addr_ff == asp_pkg::OFF_TXD && !txf_in_ready))
                      ? asp_pkg::RESP_SLVERR : asp_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= is_mapped(s_axi_araddr) ? asp_pkg::RESP_OKAY
                                             : asp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Transmitter.
  wire tx_tick = (tx_cnt_ff == baud_ff);
  wire tx_last = (tx_bit_ff[2:0] == cfg.len_m1);
  assign txf_pop = (tx_st_ff == asp_pkg::TX_IDLE) & ctrl_ff[0] & txf_valid;
  wire tx_line = (tx_st_ff == asp_pkg::TX_START) ? 1'b0 :
                 (tx_st_ff == asp_pkg::TX_DATA)  ? tx_shift_ff[0] :
                 (tx_st_ff == asp_pkg::TX_ADDR)  ? tx_addr_ff :
                 (tx_st_ff == asp_pkg::TX_PAR)   ? tx_par_ff ^ cfg.par_odd :
                 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_ff    <= asp_pkg::TX_IDLE;
      tx_cnt_ff   <= 16'h0000;
      tx_bit_ff   <= 4'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff   <= 1'b0;
      tx_addr_ff  <= 1'b0;
      tx_pin_ff   <= 1'b1;
    end else begin
      tx_pin_ff <= tx_line;
      tx_cnt_ff <= (tx_st_ff == asp_pkg::TX_IDLE || tx_tick) ? 16'h0000
                                                             : tx_cnt_ff + 1'b1;
      case (tx_st_ff)
        asp_pkg::TX_IDLE: begin
          tx_bit_ff <= 4'h0;
          tx_par_ff <= 1'b0;
          if (txf_pop) begin
            tx_shift_ff <= txf_data;
            tx_addr_ff  <= ctrl_ff[asp_pkg::CB_TXADDR];
            tx_st_ff    <= (cfg.idle_mode && ctrl_ff[asp_pkg::CB_TXADDR])
                           ? asp_pkg::TX_GAP : asp_pkg::TX_START;
          end
        end
        asp_pkg::TX_GAP: if (tx_tick) begin
          tx_bit_ff <= tx_bit_ff + 1'b1;
          if (tx_bit_ff == 4'(asp_pkg::IDLE_GAP_BITS - 1)) begin
            tx_bit_ff <= 4'h0;
            tx_st_ff  <= asp_pkg::TX_START;
          end
        end
        asp_pkg::TX_START: if (tx_tick) begin
          tx_st_ff <= asp_pkg::TX_DATA;
        end
        asp_pkg::TX_DATA: if (tx_tick) begin
          tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
          tx_par_ff   <= tx_par_ff ^ tx_shift_ff[0];
          tx_bit_ff   <= tx_bit_ff + 1'b1;
          if (tx_last) begin
            tx_bit_ff <= 4'h0;
            tx_st_ff  <= cfg.addr_mode ? asp_pkg::TX_ADDR :
                         cfg.par_en ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
          end
        end
        asp_pkg::TX_ADDR: if (tx_tick) begin
          tx_par_ff <= tx_par_ff ^ tx_addr_ff;
          tx_st_ff  <= cfg.par_en ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
        end
        asp_pkg::TX_PAR: if (tx_tick) begin
          tx_st_ff <= asp_pkg::TX_STOP;
        end
        asp_pkg::TX_STOP: if (tx_tick) begin
          tx_bit_ff <= tx_bit_ff + 1'b1;
          if (tx_bit_ff[0] == cfg.two_stop) begin
            tx_st_ff <= asp_pkg::TX_IDLE;
          end
        end
        default: tx_st_ff <= asp_pkg::TX_IDLE;
      endcase
    end
  end

  // Receiver.
  wire rx_tick  = (rx_cnt_ff == baud_ff);
  wire rx_half  = (rx_cnt_ff == {1'b0, baud_ff[15:1]});
  wire rx_fall  = rx_prev_ff & ~serial_rx_pin;
  wire rx_last  = (rx_bit_ff[2:0] == cfg.len_m1);
  wire rx_is_ad = cfg.addr_mode ? rx_addr_ff :
                  cfg.idle_mode ? rx_idle_addr_ff : 1'b1;
  wire rx_done  = (rx_st_ff == asp_pkg::RX_STOP) & rx_tick;
  wire rx_keep  = ~ctrl_ff[asp_pkg::CB_SLEEP] | rx_is_ad;
  assign rx_push = rx_done & rx_keep;
  assign rx_word = rx_shift_ff >> (3'h7 - cfg.len_m1);

  // Error flags: a new event in the clearing cycle survives the clear.
  wire [3:0] err_set;
  assign err_set[asp_pkg::EB_BRK] = rx_done & ~serial_rx_pin & ~rx_ones_ff;
  assign err_set[asp_pkg::EB_FRM] = rx_done & ~serial_rx_pin;
  assign err_set[asp_pkg::EB_OVR] = rx_push & ~sk_in_ready;
  assign err_set[asp_pkg::EB_PAR] = (rx_st_ff == asp_pkg::RX_PAR) & rx_tick &
                                    (rx_par_ff ^ serial_rx_pin ^ cfg.par_odd);
  wire [3:0] err_clr = wr_stat ? {w_data_ff[7], w_data_ff[6], w_data_ff[5],
                                  w_data_ff[3]} : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_ff <= 4'h0;
    end else begin
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_ff        <= asp_pkg::RX_IDLE;
      rx_cnt_ff       <= 16'h0000;
      ab_cnt_ff       <= 17'h00000;
      rx_bit_ff       <= 4'h0;
      idle_bits_ff    <= 4'h0;
      rx_shift_ff     <= 8'h00;
      rx_par_ff       <= 1'b0;
      rx_ones_ff      <= 1'b0;
      rx_addr_ff      <= 1'b0;
      rx_idle_addr_ff <= 1'b0;
      rx_prev_ff      <= 1'b1;
    end else begin
      rx_prev_ff <= serial_rx_pin;
      rx_cnt_ff  <= rx_tick ? 16'h0000 : rx_cnt_ff + 1'b1;
      case (rx_st_ff)
        asp_pkg::RX_IDLE: begin
          rx_bit_ff  <= 4'h0;
          rx_par_ff  <= 1'b0;
          rx_ones_ff <= 1'b0;
          if (rx_tick) begin
            idle_bits_ff <= !serial_rx_pin ? 4'h0 :
                            (&idle_bits_ff) ? idle_bits_ff
                                            : idle_bits_ff + 1'b1;
          end
          if (rx_fall && ctrl_ff[asp_pkg::CB_RX_EN]) begin
            rx_cnt_ff       <= 16'h0000;
            ab_cnt_ff       <= 17'h00001;
            rx_idle_addr_ff <= (idle_bits_ff >=
                                4'(asp_pkg::IDLE_DET_BITS));
            rx_st_ff        <= ctrl_ff[asp_pkg::CB_ABAUD]
                               ? asp_pkg::RX_BAUD : asp_pkg::RX_START;
          end
        end
        asp_pkg::RX_BAUD: begin
          if (!(&ab_cnt_ff)) ab_cnt_ff <= ab_cnt_ff + 1'b1;
          if (serial_rx_pin) begin
            idle_bits_ff <= 4'h0;
            rx_st_ff     <= asp_pkg::RX_IDLE;
          end
        end
        asp_pkg::RX_START: if (rx_half) begin
          rx_cnt_ff <= 16'h0000;
          rx_st_ff  <= serial_rx_pin ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
        end
        asp_pkg::RX_DATA: if (rx_tick) begin
          rx_shift_ff <= {serial_rx_pin, rx_shift_ff[7:1]};
          rx_par_ff   <= rx_par_ff ^ serial_rx_pin;
          rx_ones_ff  <= rx_ones_ff | serial_rx_pin;
          rx_bit_ff   <= rx_bit_ff + 1'b1;
          if (rx_last) begin
            rx_st_ff <= cfg.addr_mode ? asp_pkg::RX_ADDR :
                        cfg.par_en ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
          end
        end
        asp_pkg::RX_ADDR: if (rx_tick) begin
          rx_addr_ff <= serial_rx_pin;
          rx_par_ff  <= rx_par_ff ^ serial_rx_pin;
          rx_ones_ff <= rx_ones_ff | serial_rx_pin;
          rx_st_ff   <= cfg.par_en ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
        end
        asp_pkg::RX_PAR: if (rx_tick) begin
          rx_ones_ff <= rx_ones_ff | serial_rx_pin;
          rx_st_ff   <= asp_pkg::RX_STOP;
        end
        asp_pkg::RX_STOP: if (rx_tick) begin
          idle_bits_ff <= 4'h0;
          rx_st_ff     <= asp_pkg::RX_IDLE;
        end
        default: rx_st_ff <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // Software registers; autobaud result overrides the divisor.
  wire ab_end = (rx_st_ff == asp_pkg::RX_BAUD) & serial_rx_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= asp_pkg::CTRL_RST;
      frame_ff <= asp_pkg::FRAME_RST;
      baud_ff  <= asp_pkg::BAUD_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= w_data_ff;
      if (wr_frame) frame_ff <= w_data_ff;
      if (wr_bhi) baud_ff[15:8] <= w_data_ff;
      if (wr_blo) baud_ff[7:0] <= w_data_ff;
      if (txf_pop && !wr_ctrl) ctrl_ff[asp_pkg::CB_TXADDR] <= 1'b0;
      if (ab_end) begin
        baud_ff <= (|ab_cnt_ff[16:15]) ? 16'hffff : 16'(ab_cnt_ff - 1'b1);
        if (!wr_ctrl) ctrl_ff[asp_pkg::CB_ABAUD] <= 1'b0;
      end
    end
  end

  a_tx_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_ff == asp_pkg::TX_IDLE) ##1 (tx_st_ff == asp_pkg::TX_IDLE)
    |-> serial_tx_pin) else $error("tx line not high while idle");
  a_tx_start_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_st_ff == asp_pkg::TX_START) |=> !serial_tx_pin)
    else $error("start bit not low");
  a_tx_bit_const: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_cnt_ff > 16'h0001) |-> $stable(serial_tx_pin))
    else $error("tx level changed inside a bit");
  a_tx_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_ff == asp_pkg::TX_IDLE) && !ctrl_ff[asp_pkg::CB_TX_EN]
    |=> (tx_st_ff == asp_pkg::TX_IDLE)) else $error("tx ran disabled");
  a_fifo_full: assert property (@(posedge aclk) disable iff (!aresetn)
    (txf_level == LW'(DEPTH)) |-> !stat[0])
    else $error("buffer free while tx fifo full");
  a_frame_err: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_done && !serial_rx_pin |=> err_ff[asp_pkg::EB_FRM] && stat[4])
    else $error("low stop bit not flagged");
  a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_push && !sk_in_ready |=> err_ff[asp_pkg::EB_OVR])
    else $error("overrun not flagged");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("upper read bits not zero");
  a_emu_match: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && (s_axi_araddr == asp_pkg::OFF_RXEMU)
    |=> (rdata_ff == $past(rxf_data))) else $error("emu read wrong");
  a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_tick && (tx_st_ff != asp_pkg::TX_IDLE) && (baud_ff > 16'h0001)
    |=> !tx_tick ##1 !tx_tick) else $error("bit period too short");
endmodule

// ===== verification/asp_peer.sv
// Remote serial device: sends frames on demand, captures sent ones.
// Assumes BIT clocks a bit, no parity and a line that idles high.
`timescale 1ns/1ps
module asp_peer #(
  parameter int BIT = 4
) (
  // Clock
  input  wire logic aclk,
  // Serial line
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got;
  int         n_got = 0;
  initial line_out = 1'b1;
  // A trailing idle bit returns the line high even after a low stop.
  task automatic send(input logic [7:0] d, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge aclk);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge aclk);
    n_got++;
  end
endmodule

// ===== verification/tb.sv
// Bench: AXI4-Lite register tasks and a serial peer.
// Assumes a divisor of 3, four clocks a bit.
`timescale 1ns/1ps
module tb;
  logic        aclk, awr, wr, bv, arr, rv, tx, rx, ti, ri;
  logic        aresetn = 1'b0, awv = 1'b0, wv = 1'b0;
  logic        bq = 1'b0, arv = 1'b0, rq = 1'b0;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  br, rr, resp;
  int          n_errors = 0, checks_done = 0;
  asp_uart i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .serial_tx_pin(tx), .serial_rx_pin(rx),
    .tx_irq(ti), .rx_irq(ri));
  asp_peer #(.BIT(4)) i_peer (.aclk(aclk), .line_in(tx), .line_out(rx));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    while (bv !== 1'b1) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    resp = br;
    bq <= 1'b0;
  endtask
  // Reads a register and compares the masked word.
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    while (rv !== 1'b1) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    resp = rr;
    rq <= 1'b0;
    chk(rd & m, e);
  endtask
  // The extra bit period lets the stop bit finish on the line.
  task automatic wait_rx(input int n);
    while (i_peer.n_got < n) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(8'h00, '1, 32'h0);
    rreg(8'h04, '1, 32'h7);
    rreg(8'h0c, '1, 32'h40);
    rreg(8'h1c, '1, 32'h3);
    rreg(8'h28, '1, 32'h0);
    chk({30'h0, resp}, {30'h0, asp_pkg::RESP_SLVERR});
    wreg(8'h0c, 32'h1234_ab03);
    rreg(8'h0c, '1, 32'h3);
    for (int i = 0; i < 17; i++)
      wreg(8'h10, 32'h10 + i);
    chk({30'h0, resp}, {30'h0, asp_pkg::RESP_SLVERR});
    rreg(8'h20, '1, 32'h10);
    rreg(8'h1c, '1, 32'h2);
    wreg(8'h00, 32'h3);
    wait_rx(16);
    chk({24'h0, i_peer.got}, 32'h1f);
    rreg(8'h1c, '1, 32'h3);
    i_peer.send(8'h3c, 1'b1);
    i_peer.send(8'hc3, 1'b1);
    rreg(8'h24, '1, 32'h2);
    rreg(8'h18, '1, 32'h3c);
    rreg(8'h14, '1, 32'h3c);
    rreg(8'h14, '1, 32'hc3);
    i_peer.send(8'h55, 1'b0);
    rreg(8'h1c, 32'h9c, 32'h94);
    wreg(8'h1c, 32'hff);
    i_peer.send(8'h00, 1'b0);
    rreg(8'h1c, 32'h9c, 32'h9c);
    // A start bit of four clocks must bring the divisor back to 3.
    wreg(8'h0c, 32'h10);
    wreg(8'h00, 32'h23);
    i_peer.send(8'hff, 1'b1);
    rreg(8'h0c, '1, 32'h3);
    rreg(8'h00, '1, 32'h3);
    // With even parity on, the stop slot carries a wrong parity bit.
    wreg(8'h04, 32'h0f);
    i_peer.send(8'h01, 1'b0);
    rreg(8'h1c, 32'h20, 32'h20);
    wreg(8'h00, 32'h0b);
    chk({30'h0, ti, ri}, 32'h1);
    wreg(8'h00, 32'h14);
    chk({30'h0, ti, ri}, 32'h3);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim;
  end
endmodule
